// [src/eit_pkg.sv]
// Constants and clock-select decoding for the three-channel interval timer
package eit_pkg;
  localparam logic [15:0] EIT_ADDR_PORT2_DIR = 16'hff22;
  localparam logic [15:0] EIT_ADDR_CSEL0 = 16'hff71;
  localparam logic [15:0] EIT_ADDR_CSEL1 = 16'hff75;
  localparam logic [15:0] EIT_ADDR_CSEL2 = 16'hff79;
  localparam logic [7:0] EIT_PORT2_DIR_RST = 8'hff;
  localparam logic [2:0] EIT_CSEL_RST = 3'h0;
  localparam int EIT_CSEL_W = 3;
  localparam int EIT_SHIFT_W = 4;
  localparam int EIT_PRE_W = 11;
  localparam logic [2:0] EIT_CODE_FALL = 3'h0;
  localparam logic [2:0] EIT_CODE_RISE = 3'h1;
  localparam logic [3:0] EIT_CH0_BASE = 4'h1;
  localparam logic [3:0] EIT_CH1_BASE = 4'h0;
  localparam logic [3:0] EIT_CH2_BASE = 4'h4;

  // Division exponent for codes 2..7; channel 0 steps by two exponents
  function automatic logic [3:0] eit_shift(input int ch, input logic [2:0] code);
    logic [3:0] idx;
    idx = {1'b0, code} - 4'h2;
    if (ch == 0)
      eit_shift = EIT_CH0_BASE + {idx[2:0], 1'b0};
    else if (ch == 1)
      eit_shift = EIT_CH1_BASE + idx;
    else
      eit_shift = EIT_CH2_BASE + idx;
  endfunction
endpackage

// [src/eit_channel.sv]
// One 8-bit interval counter with its own prescaler
`timescale 1ns/1ps
`default_nettype none
module eit_channel
  import eit_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic use_ext,
  input wire logic ext_tick,
  input wire logic [EIT_SHIFT_W-1:0] shift,
  input wire logic [WIDTH-1:0] compare,
  output logic [WIDTH-1:0] count,
  output logic match
);
  logic [EIT_PRE_W-1:0] pre_r;
  logic [EIT_PRE_W-1:0] mask;
  logic tick;

  assign mask = EIT_PRE_W'((12'h001 << shift) - 12'h001);
  assign tick = use_ext ? ext_tick : ((pre_r & mask) == mask);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_r <= '0;
    else if (!enable)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
      match <= 1'b0;
    end
    else if (!enable)
    begin
      count <= '0;
      match <= 1'b0;
    end
    else if (tick && count == compare)
    begin
      // Count 0..N then clear gives N+1 ticks per request
      count <= '0;
      match <= 1'b1;
    end
    else
    begin
      // Natural wrap past 255 lets a lowered compare match next pass
      if (tick)
        count <= count + 1'b1;
      match <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [src/eit_top.sv]
// Three interval counters, clock selectors and port-2 direction register
`timescale 1ns/1ps
`default_nettype none
module eit_top
  import eit_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input wire logic [2:0] event_input,
  input wire logic [2:0] count_enable,
  input wire logic cascade1,
  input wire logic cascade2,
  input wire logic [7:0] compare_value0,
  input wire logic [7:0] compare_value1,
  input wire logic [7:0] compare_value2,
  output logic [7:0] up_counter0,
  output logic [7:0] up_counter1,
  output logic [7:0] up_counter2,
  output logic [2:0] match_irq,
  output logic [7:0] port2_direction
);
  logic rst_meta_r;
  logic rst_n;
  logic [2:0] ev_s1_r;
  logic [2:0] ev_s2_r;
  logic [2:0] ev_s3_r;
  logic [EIT_CSEL_W-1:0] csel_r [3];
  logic [7:0] cmp [3];
  logic [7:0] cnt [3];
  logic [2:0] match;
  logic [2:1] casc;
  logic hit_dir;
  logic [2:0] hit_csel;
  logic [7:0] rdata_nxt;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_s1_r <= '0;
      ev_s2_r <= '0;
      ev_s3_r <= '0;
    end
    else
    begin
      ev_s1_r <= event_input;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  // One decode shared by reads and writes
  always_comb
  begin
    hit_dir = 1'b0;
    hit_csel = 3'h0;
    if (mem_addr == EIT_ADDR_PORT2_DIR)
      hit_dir = 1'b1;
    else if (mem_addr == EIT_ADDR_CSEL0)
      hit_csel = 3'h1;
    else if (mem_addr == EIT_ADDR_CSEL1)
      hit_csel = 3'h2;
    else if (mem_addr == EIT_ADDR_CSEL2)
      hit_csel = 3'h4;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      port2_direction <= EIT_PORT2_DIR_RST;
    else if (mem_wr && hit_dir)
      port2_direction <= {1'b1, mem_wdata[6:0]};
  end

  // Unmapped addresses read as zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (hit_dir)
      rdata_nxt = port2_direction;
    else if (hit_csel[0])
      rdata_nxt = {5'h00, csel_r[0]};
    else if (hit_csel[1])
      rdata_nxt = {5'h00, csel_r[1]};
    else if (hit_csel[2])
      rdata_nxt = {5'h00, csel_r[2]};
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mem_rdata <= 8'h00;
    else if (mem_rd)
      mem_rdata <= rdata_nxt;
  end

  assign cmp[0] = compare_value0;
  assign cmp[1] = compare_value1;
  assign cmp[2] = compare_value2;
  assign casc = {cascade2, cascade1};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ch
      logic use_ext;
      logic ext_tick;
      logic edge_tick;
      logic [EIT_SHIFT_W-1:0] shift;
      assign edge_tick = (csel_r[g] == EIT_CODE_FALL) ?
        (ev_s3_r[g] & ~ev_s2_r[g]) : (~ev_s3_r[g] & ev_s2_r[g]);
      assign shift = eit_shift(g, csel_r[g]);
      // Low three bits only; upper bits read back as zero
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          csel_r[g] <= EIT_CSEL_RST;
        else if (mem_wr && hit_csel[g])
          csel_r[g] <= mem_wdata[EIT_CSEL_W-1:0];
      end
      if (g == 0)
      begin : g_base
        assign use_ext = (csel_r[g] <= EIT_CODE_RISE);
        assign ext_tick = edge_tick;
      end
      else
      begin : g_chain
        // Upper half steps on the lower half's match, own code unused
        assign use_ext = casc[g] | (csel_r[g] <= EIT_CODE_RISE);
        assign ext_tick = casc[g] ? match[g-1] : edge_tick;
      end
      eit_channel #(.WIDTH(8)) u_ch (
        .clk(clk),
        .rst_n(rst_n),
        .enable(count_enable[g]),
        .use_ext(use_ext),
        .ext_tick(ext_tick),
        .shift(shift),
        .compare(cmp[g]),
        .count(cnt[g]),
        .match(match[g])
      );
    end
  endgenerate

  assign up_counter0 = cnt[0];
  assign up_counter1 = cnt[1];
  assign up_counter2 = cnt[2];
  assign match_irq = match;
endmodule
`default_nettype wire

// [bench/eit_event_src.sv]
// Event pulse source standing on the three timer input pins
`timescale 1ns/1ps
`default_nettype none
module eit_event_src
(
  input wire logic clk,
  output logic [2:0] ev
);
  // Idle low as if pulled down; wide pulses outlast the synchroniser
  initial ev = 3'h0;
  task pulse(input int n, input int ch);
    repeat (n)
    begin
      @(posedge clk) ev[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      ev[ch] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// [bench/eit_monitor.sv]
// Port checker for the interval timer
`timescale 1ns/1ps
`default_nettype none
module eit_monitor
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] count_enable,
  input wire logic cascade1,
  input wire logic [7:0] compare_value0,
  input wire logic [7:0] up_counter0,
  input wire logic [7:0] up_counter1,
  input wire logic [7:0] up_counter2,
  input wire logic [2:0] match_irq,
  input wire logic [7:0] port2_direction
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_DIR_B7: assert property (port2_direction[7])
    else $error("direction bit 7 low");
  AST_MATCH_CLR: assert property (match_irq[1] |-> up_counter1 == 8'h00)
    else $error("count not cleared on match");
  AST_MATCH_CAUSE: assert property (match_irq[0] |->
    $past(up_counter0) == $past(compare_value0))
    else $error("match without equal compare");
  AST_PULSE0: assert property (match_irq[0] |=> !match_irq[0])
    else $error("counter 0 match too close");
  AST_STEP: assert property (($changed(up_counter0) && count_enable[0]
    && $past(count_enable[0])) |-> (up_counter0 == $past(up_counter0) + 8'h01
    || up_counter0 == 8'h00))
    else $error("counter 0 skipped a value");
  AST_STOP: assert property (!count_enable[0] ##1 !count_enable[0]
    |-> up_counter0 == 8'h00)
    else $error("stopped counter not zero");
  AST_START: assert property ($rose(count_enable[2]) |-> up_counter2 == 8'h00)
    else $error("counter 2 not started from zero");
  AST_CASC: assert property (($changed(up_counter1) && cascade1
    && $past(cascade1) && count_enable[1] && $past(count_enable[1]))
    |-> $past(match_irq[0]) || $past(match_irq[0], 2))
    else $error("upper half moved without lower match");
  CV_CASC: cover property (cascade1 && match_irq[0]);
  CV_WRAP: cover property (up_counter1 == 8'hff ##1 up_counter1 == 8'h00);
  CV_STOP: cover property ($fell(count_enable[2]));
endmodule
`default_nettype wire

// [bench/eit_tb.sv]
// Self-checking bench for the interval timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end
module eit_tb;
  import eit_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
  logic cascade1 = 1'b0, cascade2 = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0] mem_wdata = 8'h00, mem_rdata, port2_direction;
  logic [2:0] count_enable = 3'h0, match_irq;
  logic [7:0] cmp[3] = '{8'h00, 8'h00, 8'h00};
  wire [7:0] cnt[3];
  wire [2:0] ev;
  int n_errors = 0, n_checks = 0, n, m;
  int dexp[3][6] = '{'{1, 3, 5, 7, 9, 11}, '{0, 1, 2, 3, 4, 5},
    '{4, 5, 6, 7, 8, 9}};
  eit_top dut (.*, .event_input(ev), .compare_value0(cmp[0]),
    .compare_value1(cmp[1]), .compare_value2(cmp[2]),
    .up_counter0(cnt[0]), .up_counter1(cnt[1]), .up_counter2(cnt[2]));
  eit_event_src src (.clk(clk), .ev(ev));
  initial forever #5 clk = ~clk;
  task close_out;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    #1 `CHK(mem_rdata, e)
  endtask
  task wt(input int ch, output int k);
    for (k = 0; k < 20000 && match_irq[ch] !== 1'b1; k++) @(posedge clk) #1;
  endtask
  initial
  begin
    repeat (80000) @(posedge clk);
    n_errors++;
    close_out;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // Clock code written only while stopped, enable set last
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 6; k++)
      begin
        wr(EIT_ADDR_CSEL0 + 16'(4 * c), 8'(k + 2));
        cmp[c] <= 8'(k);
        count_enable[c] <= 1'b1;
        wt(c, n);
        @(posedge clk) #1;
        wt(c, n);
        `CHK(n + 1, (k + 1) << dexp[c][k])
        @(posedge clk) count_enable[c] <= 1'b0;
      end
    wr(EIT_ADDR_PORT2_DIR, 8'h00);
    #1 `CHK(port2_direction, 8'h80)
    rd(EIT_ADDR_PORT2_DIR, 8'h80);
    wr(EIT_ADDR_CSEL2, 8'hff);
    rd(EIT_ADDR_CSEL2, 8'h07);
    rd(16'hff23, 8'h00);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(EIT_ADDR_PORT2_DIR, 8'hff);
    for (int c = 0; c < 3; c++)
      rd(EIT_ADDR_CSEL0 + 16'(4 * c), 8'h00);
    // Falling then rising edge code on every channel
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 2; k++)
      begin
        wr(EIT_ADDR_CSEL0 + 16'(4 * c), 8'(k));
        cmp[c] <= 8'hff;
        count_enable[c] <= 1'b1;
        src.pulse(3, c);
        repeat (6) @(posedge clk);
        #1 `CHK(cnt[c], 8'h03)
        @(posedge clk) count_enable[c] <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK(cnt[c], 8'h00)
      end
    wr(EIT_ADDR_CSEL0, 8'h02);
    wr(EIT_ADDR_CSEL1, 8'h02);
    cmp[0] <= 8'h01;
    cmp[1] <= 8'hff;
    cascade1 <= 1'b1;
    count_enable <= 3'h3;
    m = 0;
    for (int i = 0; i < 45; i++)
    begin
      @(posedge clk);
      if (i == 40) count_enable[0] <= 1'b0;
      #1 m += match_irq[0];
    end
    `CHK(cnt[1], 8'(m))
    @(posedge clk) count_enable <= 3'h0;
    cascade1 <= 1'b0;
    cmp[1] <= 8'd200;
    @(posedge clk) count_enable[1] <= 1'b1;
    for (n = 0; n < 99 && cnt[1] !== 8'd50; n++) @(posedge clk) #1;
    @(posedge clk) cmp[1] <= 8'h0a;
    #1 wt(1, n);
    // Count runs on from 51 through 255 and 0 up to the new compare
    `CHK(n, 32'h100 - 32'h32 + 32'ha)
    close_out;
  end
endmodule
bind eit_top eit_monitor mon (.*);
`default_nettype wire
